// ---- logic/smr_pkg.sv ----
// Constants and types for the fifth mode register block.
// Assumes the command word is captured on the memory clock and handed to the core clock.
package smr_pkg;

  // ----------------------------------------------------------------------
  // Register layout
  // ----------------------------------------------------------------------
  localparam int           MR_W        = 22;
  localparam logic [21:0]  MR_RESET    = 22'h000000; // Parity off, all modes off.
  localparam int           SEL_HI      = 20;
  localparam int           SEL_LO      = 18;
  localparam logic [2:0]   SEL_SELF    = 3'h5;       // Code that targets this register.
  localparam logic [2:0]   SEL_DNU     = 3'h7;       // The do_not_use_code.
  localparam int           RD_DBI_BIT  = 12;
  localparam int           WR_DBI_BIT  = 11;
  localparam int           WMASK_BIT   = 10;
  localparam int           PERSIST_BIT = 9;
  localparam int           PARK_HI     = 8;
  localparam int           PARK_LO     = 6;
  localparam int           ODT_OFF_BIT = 5;
  localparam int           PAR_ERR_BIT = 4;
  localparam int           CRC_ERR_BIT = 3;
  localparam int           LAT_HI      = 2;
  localparam int           LAT_LO      = 0;

  // ----------------------------------------------------------------------
  // Parity latency codes and clock counts
  // ----------------------------------------------------------------------
  localparam logic [2:0]   LAT_OFF     = 3'h0;
  localparam logic [2:0]   LAT_C4      = 3'h1;
  localparam logic [2:0]   LAT_C5      = 3'h2;
  localparam logic [2:0]   LAT_C6      = 3'h3;
  localparam logic [2:0]   LAT_C8      = 3'h4;
  localparam logic [3:0]   LAT_N4      = 4'h4;
  localparam logic [3:0]   LAT_N5      = 4'h5;
  localparam logic [3:0]   LAT_N6      = 4'h6;
  localparam logic [3:0]   LAT_N8      = 4'h8;

  // Function of the shared mask / inversion pin.
  typedef enum logic [2:0] {
    PIN_NONE = 3'b001,
    PIN_DBI  = 3'b010,
    PIN_MASK = 3'b100
  } smr_pinfn_t;

  // One command as it stands on the command/address pins.
  typedef struct packed {
    logic        act_n;
    logic        ras_n;  // Also A16.
    logic        cas_n;  // Also A15.
    logic        we_n;   // Also A14.
    logic [1:0]  bg;
    logic [1:0]  ba;
    logic        a17;
    logic [13:0] addr;
    logic        par;    // The command_parity_bit.
  } smr_ca_t;

endpackage

// ---- logic/smr_top.sv ----
// Fifth mode register: load, decode, parity check and sticky error flags.
// Assumes CK_LINK_I is the free running memory command clock and CLK_I the core clock.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// RULE1: Load only by MRS; pins map to bits.
// RULE2: Controller holds RAS, CAS, WE low.
// RULE3: Bits 20:18 select register; 111 unused.
// RULE4: Controller writes reserved bits 21,17,13 zero.
// RULE5: Bit 12 read inversion, bit 11 write.
// RULE6: Controller never enables write inversion with mask.
// RULE7: Multipurpose readout never inverts read data.
// RULE8: Bit 10 mask acts on writes only.
// RULE9: Inversion and mask only x8, x16, shared pin.
// RULE10: Non-persistent mode stops checking while error set.
// RULE11: Bits 8:6 select parked termination strength.
// RULE12: Bit 5 ignores ODT during power-down.
// RULE13: Controller keeps ODT valid if buffer on.
// RULE14: Parity error sets sticky bit 4.
// RULE15: CRC error sets sticky bit 3.
// RULE16: Bits 2:0 parity latency 4,5,6,8.
// RULE17: No 5-clock latency with quarter-rate gear-down.
// RULE18: Parity checking off after reset.
// RULE19: Command failing parity is not executed.
// RULE20: Parity covers ACT, RAS, CAS, WE, address, bank.
// RULE21: Even parity; odd count flags error.
// RULE22: Writing zero clears flag, one keeps.
module smr_top (
  input  wire logic               CLK_I,        // Core clock, 125 MHz.
  input  wire logic               SRST_I,       // Synchronous reset, active high.
  input  wire logic               CK_LINK_I,    // Memory command clock.
  input  wire logic               CS_N_I,       // Chip select, active low.
  input  wire smr_pkg::smr_ca_t   CA_I,         // Command/address pins.
  input  wire logic               CRC_ERR_I,    // Write CRC error pulse.
  input  wire logic               MPR_READ_I,   // Multipurpose readout active.
  input  wire logic               PWRDN_I,      // Device in power-down.
  input  wire logic               ORG_X4_I,     // Organisation is x4.
  output logic                    CMD_VALID_O,  // Command cleared for execution.
  output smr_pkg::smr_ca_t        CMD_O,        // Executed command word.
  output logic [21:0]             MODE_REG_O,   // Register contents.
  output logic                    RD_DBI_O,     // Invert read data.
  output logic                    WR_DBI_O,     // Write data may be inverted.
  output logic                    WR_MASK_O,    // Write byte masking active.
  output smr_pkg::smr_pinfn_t     PIN_FN_O,     // Shared pin function.
  output logic [7:0]              PARK_OHM_O,   // Parked termination, 0 is off.
  output logic                    ODT_IGNORE_O, // ODT ignored, no nominal term.
  output logic                    PAR_CHECK_O,  // Parity checking active.
  output logic [3:0]              PAR_LAT_O     // Parity latency in clocks.
);

  // ----------------------------------------------------------------------
  // Link side: capture and hand over
  // ----------------------------------------------------------------------
  logic [2:0]        lrst_s;
  logic              lrst;
  logic              req_tgl;
  smr_pkg::smr_ca_t  cap;
  logic [2:0]        ack_s;
  logic              ack_seen;
  logic              busy;
  logic              ack_done;

  // Reset reaches the link domain through a synchroniser.
  always_ff @(posedge CK_LINK_I) begin
    lrst_s <= {lrst_s[1:0], SRST_I};
  end
  assign lrst = lrst_s[2];

  // Core acknowledgement comes back as a toggle.
  always_ff @(posedge CK_LINK_I) begin
    if (lrst) begin
      ack_s    <= 3'h0;
      ack_seen <= 1'b0;
    end else begin
      ack_s <= {ack_s[1:0], ack_done};
      if (ack_s[1] == ack_s[2]) begin
        ack_seen <= ack_s[2];
      end
    end
  end
  assign busy = req_tgl != ack_seen;

  // A selected command is held until the core has taken it.
  always_ff @(posedge CK_LINK_I) begin
    if (lrst) begin
      req_tgl <= 1'b0;
      cap     <= '0;
    end else if (!CS_N_I && !busy) begin
      req_tgl <= ~req_tgl;
      cap     <= CA_I;
    end
  end

  // ----------------------------------------------------------------------
  // Core side: receive command
  // ----------------------------------------------------------------------
  logic [2:0]  req_s;
  logic        cmd_evt;

  // The toggle counts once the second and third stages agree.
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      req_s    <= 3'h0;
      ack_done <= 1'b0;
    end else begin
      req_s <= {req_s[1:0], req_tgl};
      if (cmd_evt) begin
        ack_done <= req_s[2];
      end
    end
  end
  assign cmd_evt = (req_s[1] == req_s[2]) && (req_s[2] != ack_done);

  // ----------------------------------------------------------------------
  // Parity check and command decode
  // ----------------------------------------------------------------------
  logic [21:0]  mr;
  logic [21:0]  mrs_word;
  logic         par_odd;
  logic         chk_on;
  logic         par_fail;
  logic         is_mrs;
  logic         load;
  logic         exec;

  // Odd count over covered pins and parity bit is an error.
  assign par_odd = ^{cap.act_n, cap.ras_n, cap.cas_n, cap.we_n, cap.bg, // RULE20
                     cap.ba, cap.a17, cap.addr, cap.par};              // RULE21

  // Checking needs a nonzero latency code and, unless persistent, a clear flag.
  assign chk_on = (mr[smr_pkg::LAT_HI:smr_pkg::LAT_LO] != smr_pkg::LAT_OFF) // RULE18
                  && (mr[smr_pkg::PERSIST_BIT] || !mr[smr_pkg::PAR_ERR_BIT]); // RULE10
  assign par_fail = cmd_evt && chk_on && par_odd;
  assign exec     = cmd_evt && !(chk_on && par_odd); // RULE19

  // Mode register set decode and pin to bit mapping.
  assign is_mrs   = !cap.act_n && !cap.ras_n && !cap.cas_n && !cap.we_n;
  assign mrs_word = {cap.bg, cap.ba, cap.a17, 3'h0, cap.addr}; // RULE1
  assign load     = exec && is_mrs
                    && (mrs_word[smr_pkg::SEL_HI:smr_pkg::SEL_LO] == smr_pkg::SEL_SELF); // RULE3

  // ----------------------------------------------------------------------
  // Register and sticky flags
  // ----------------------------------------------------------------------
  logic next_par_err;
  logic next_crc_err;

  // A set arriving with a clear wins; writing one keeps the flag.
  always_comb begin
    next_par_err = mr[smr_pkg::PAR_ERR_BIT];
    next_crc_err = mr[smr_pkg::CRC_ERR_BIT];
    if (load && !mrs_word[smr_pkg::PAR_ERR_BIT]) begin
      next_par_err = 1'b0; // RULE22
    end
    if (load && !mrs_word[smr_pkg::CRC_ERR_BIT]) begin
      next_crc_err = 1'b0; // RULE22
    end
    if (par_fail) begin
      next_par_err = 1'b1; // RULE14
    end
    if (CRC_ERR_I) begin
      next_crc_err = 1'b1; // RULE15
    end
  end

  // Only a mode register set to this register changes the other bits.
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      mr <= smr_pkg::MR_RESET; // RULE18
    end else begin
      if (load) begin
        mr <= mrs_word; // RULE1
      end
      mr[smr_pkg::PAR_ERR_BIT] <= next_par_err;
      mr[smr_pkg::CRC_ERR_BIT] <= next_crc_err;
    end
  end

  // Executed commands are passed on from flip-flops.
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      CMD_VALID_O <= 1'b0;
      CMD_O       <= '0;
    end else begin
      CMD_VALID_O <= exec; // RULE19
      if (exec) begin
        CMD_O <= cap;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Decoded controls
  // ----------------------------------------------------------------------
  logic x8x16;

  assign x8x16 = !ORG_X4_I; // RULE9

  // Inversion and mask controls from their enable bits.
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      RD_DBI_O  <= 1'b0;
      WR_DBI_O  <= 1'b0;
      WR_MASK_O <= 1'b0;
      PIN_FN_O  <= smr_pkg::PIN_NONE;
    end else begin
      RD_DBI_O  <= mr[smr_pkg::RD_DBI_BIT] && x8x16 && !MPR_READ_I; // RULE5 RULE7
      WR_DBI_O  <= mr[smr_pkg::WR_DBI_BIT] && x8x16;                // RULE5
      WR_MASK_O <= mr[smr_pkg::WMASK_BIT] && x8x16;                 // RULE8
      if (!x8x16) begin
        PIN_FN_O <= smr_pkg::PIN_NONE;
      end else if (mr[smr_pkg::WMASK_BIT]) begin
        PIN_FN_O <= smr_pkg::PIN_MASK; // RULE9
      end else if (mr[smr_pkg::RD_DBI_BIT] || mr[smr_pkg::WR_DBI_BIT]) begin
        PIN_FN_O <= smr_pkg::PIN_DBI;  // RULE9
      end else begin
        PIN_FN_O <= smr_pkg::PIN_NONE;
      end
    end
  end

  // Parked termination strength against the 240 ohm reference resistor.
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      PARK_OHM_O <= 8'h00;
    end else begin
      case (mr[smr_pkg::PARK_HI:smr_pkg::PARK_LO]) // RULE11
        3'h1:    PARK_OHM_O <= 8'h3C;
        3'h2:    PARK_OHM_O <= 8'h78;
        3'h3:    PARK_OHM_O <= 8'h28;
        3'h4:    PARK_OHM_O <= 8'hF0;
        3'h5:    PARK_OHM_O <= 8'h30;
        3'h6:    PARK_OHM_O <= 8'h50;
        3'h7:    PARK_OHM_O <= 8'h22;
        default: PARK_OHM_O <= 8'h00;
      endcase
    end
  end

  // Parity latency in clocks; reserved codes read as 0.
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      PAR_LAT_O <= 4'h0;
    end else begin
      case (mr[smr_pkg::LAT_HI:smr_pkg::LAT_LO]) // RULE16
        smr_pkg::LAT_C4: PAR_LAT_O <= smr_pkg::LAT_N4;
        smr_pkg::LAT_C5: PAR_LAT_O <= smr_pkg::LAT_N5;
        smr_pkg::LAT_C6: PAR_LAT_O <= smr_pkg::LAT_N6;
        smr_pkg::LAT_C8: PAR_LAT_O <= smr_pkg::LAT_N8;
        default:         PAR_LAT_O <= 4'h0;
      endcase
    end
  end

  assign MODE_REG_O   = mr;
  assign PAR_CHECK_O  = chk_on;
  assign ODT_IGNORE_O = PWRDN_I && mr[smr_pkg::ODT_OFF_BIT]; // RULE12

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);

  reset_off_a: assert property ( // RULE18
    $fell(SRST_I) |-> !chk_on)
    else $error("Parity check active after reset.");
  par_set_a: assert property ( // RULE14
    par_fail |=> mr[smr_pkg::PAR_ERR_BIT])
    else $error("Parity error flag not set.");
  crc_set_a: assert property ( // RULE15
    CRC_ERR_I |=> mr[smr_pkg::CRC_ERR_BIT])
    else $error("CRC error flag not set.");
  flag_keep_a: assert property ( // RULE22
    mr[smr_pkg::CRC_ERR_BIT] && !(load && !mrs_word[smr_pkg::CRC_ERR_BIT])
    |=> mr[smr_pkg::CRC_ERR_BIT])
    else $error("CRC flag dropped without clear.");
  no_exec_a: assert property ( // RULE19
    cmd_evt && chk_on && par_odd |=> !CMD_VALID_O)
    else $error("Failed command executed.");
  // With the flag set and no persistence, every arriving command is executed.
  nonpersist_a: assert property ( // RULE10
    mr[smr_pkg::PAR_ERR_BIT] && !mr[smr_pkg::PERSIST_BIT] && cmd_evt |=> CMD_VALID_O)
    else $error("Command refused while checking stopped.");
  mpr_plain_a: assert property ( // RULE7
    MPR_READ_I |=> !RD_DBI_O)
    else $error("Read inversion during readout.");
  x4_off_a: assert property ( // RULE9
    ORG_X4_I |=> !WR_MASK_O && !WR_DBI_O && PIN_FN_O == smr_pkg::PIN_NONE)
    else $error("Shared pin active on x4.");
  load_only_a: assert property ( // RULE1
    !load |=> mr[21:5] == $past(mr[21:5]))
    else $error("Register changed without load.");
  // A mode register set aimed at any other select code leaves this register alone.
  other_sel_a: assert property ( // RULE3
    exec && is_mrs && mrs_word[smr_pkg::SEL_HI:smr_pkg::SEL_LO] != smr_pkg::SEL_SELF
    |=> mr[21:5] == $past(mr[21:5]))
    else $error("Register changed by another select code.");
  lat_a: assert property ( // RULE16
    load && mrs_word[2:0] == smr_pkg::LAT_C8 |=> ##1 PAR_LAT_O == smr_pkg::LAT_N8)
    else $error("Parity latency decode wrong.");

  mrs_c: cover property (load);
  par_err_c: cover property (par_fail);
  persist_c: cover property (mr[smr_pkg::PERSIST_BIT] && mr[smr_pkg::PAR_ERR_BIT] && exec);

endmodule

`default_nettype wire

// ---- tb/smr_ctl_model.sv ----
// Behavioural memory controller that issues mode-register-set commands on the link.
// Assumes the link clock runs only from the bench and the command pins are sampled on its rising edge.
`timescale 1ns/10ps
`default_nettype none

module smr_ctl_model (
  input  wire logic            ck_link_i, // Memory command clock.
  output var  smr_pkg::smr_ca_t ca_o,     // Command/address pins.
  output var  logic            cs_n_o,    // Chip select, active low.
  output var  logic            odt_o      // Termination control pin.
);
  // -------------------------------------------------------------------
  // Idle pins
  // -------------------------------------------------------------------
  // The pins start deselected.
  initial begin
    cs_n_o = 1'b1;
    ca_o   = '0;
    odt_o  = 1'b0; // Held at a valid level through any power-down.
  end

  // -------------------------------------------------------------------
  // Command issue
  // -------------------------------------------------------------------
  // Sends one command for a whole link cycle, then keeps the spacing the design needs.
  task automatic send(input logic [21:0] v, input logic bad);
    smr_pkg::smr_ca_t c;
    c      = '0;
    c.bg   = {1'b0, v[20]};
    c.ba   = v[19:18];
    c.addr = {1'b0, v[12:0]};
    c.par  = (^c[23:1]) ^ bad;
    @(posedge ck_link_i);
    #1;
    cs_n_o = 1'b0;
    ca_o   = c;
    @(posedge ck_link_i);
    #1;
    cs_n_o = 1'b1;
    ca_o   = ~c;                  // Released pins never repeat the old command.
    repeat (4) @(posedge ck_link_i);
  endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the fifth mode register block.
// Assumes the controller model drives the link and the bench drives the core-side inputs.
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic                clk, srst, ck_link, cs_n, crc_err, mpr_rd, pwrdn, org_x4;
  logic                cmd_valid, rd_dbi, wr_dbi, wr_mask, odt_ign, par_chk;
  smr_pkg::smr_ca_t    ca, cmd;
  smr_pkg::smr_pinfn_t pin_fn;
  logic [21:0]         mode_reg, exp;
  logic [7:0]          park_ohm;
  logic [3:0]          par_lat;
  int                  fails, tests_run, execs, cyc;
  logic [7:0]          ohm_tab [8] = '{8'h00, 8'h3C, 8'h78, 8'h28, 8'hF0, 8'h30, 8'h50, 8'h22};
  logic [3:0]          lat_tab [8] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h8, 4'h0, 4'h0, 4'h0};

  smr_top u_smr_top (.CLK_I(clk), .SRST_I(srst), .CK_LINK_I(ck_link), .CS_N_I(cs_n), .CA_I(ca),
    .CRC_ERR_I(crc_err), .MPR_READ_I(mpr_rd), .PWRDN_I(pwrdn), .ORG_X4_I(org_x4),
    .CMD_VALID_O(cmd_valid), .CMD_O(cmd), .MODE_REG_O(mode_reg), .RD_DBI_O(rd_dbi),
    .WR_DBI_O(wr_dbi), .WR_MASK_O(wr_mask), .PIN_FN_O(pin_fn), .PARK_OHM_O(park_ohm),
    .ODT_IGNORE_O(odt_ign), .PAR_CHECK_O(par_chk), .PAR_LAT_O(par_lat));
  smr_ctl_model u_smr_ctl_model (.ck_link_i(ck_link), .ca_o(ca), .cs_n_o(cs_n), .odt_o());

  // -------------------------------------------------------------------
  // Clocks, execution counter and hang guard
  // -------------------------------------------------------------------
  // The core clock runs at 8 ns and the link clock at 32 ns with an offset phase.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    ck_link = 1'b0;
    #3;
    forever #16 ck_link = ~ck_link;
  end
  // Counts executed commands and stops a run that hangs.
  always @(posedge clk) begin
    if (cmd_valid === 1'b1) execs++;
    cyc++;
    if (cyc == 4000) begin
      fails++;
      print_verdict();
    end
  end

  // -------------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------------
  task automatic print_verdict();
    if (fails == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [21:0] e, input logic [21:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Sends one command and checks execution and the register image.
  task automatic wr(input logic [21:0] v, input logic bad, input logic go);
    int n0;
    n0 = execs;
    u_smr_ctl_model.send(v, bad);
    tick(6);
    if (go && v[20:18] === smr_pkg::SEL_SELF) exp = {v[21:17], 3'h0, v[13:5], exp[4:3] & v[4:3], v[2:0]};
    if (!go && bad) exp[4] = 1'b1;
    chk("executed", 22'(execs - n0), 22'(go));
    chk("mode_reg", exp, mode_reg);
  endtask

  // -------------------------------------------------------------------
  // Test sequence
  // -------------------------------------------------------------------
  initial begin
    {srst, crc_err, mpr_rd, pwrdn, org_x4} = 5'h10;
    exp = '0;
    tick(4);
    srst = 1'b0;
    repeat (6) @(posedge ck_link);
    tick(1);
    chk("mode_reg", 22'h0, mode_reg);
    chk("par_check", 22'h0, 22'(par_chk));
    chk("pin_fn", 22'(smr_pkg::PIN_NONE), 22'(pin_fn));
    wr(22'h141820, 1'b0, 1'b1);
    chk("rd_dbi", 22'h1, 22'(rd_dbi));
    chk("wr_dbi", 22'h1, 22'(wr_dbi));
    chk("pin_fn", 22'(smr_pkg::PIN_DBI), 22'(pin_fn));
    chk("odt_ignore", 22'h0, 22'(odt_ign));
    pwrdn = 1'b1;
    tick(2);
    chk("odt_ignore", 22'h1, 22'(odt_ign));
    {pwrdn, mpr_rd} = 2'h1;
    tick(3);
    chk("rd_dbi", 22'h0, 22'(rd_dbi));
    mpr_rd = 1'b0;
    wr(22'h140400, 1'b0, 1'b1);
    chk("wr_mask", 22'h1, 22'(wr_mask));
    chk("pin_fn", 22'(smr_pkg::PIN_MASK), 22'(pin_fn));
    org_x4 = 1'b1;
    tick(3);
    chk("wr_mask", 22'h0, 22'(wr_mask));
    chk("pin_fn", 22'(smr_pkg::PIN_NONE), 22'(pin_fn));
    org_x4 = 1'b0;
    for (int s = 0; s < 7; s++) begin
      if (s != 5) wr({1'b0, 3'(s), 18'h007C0}, 1'b0, 1'b1);
    end
    for (int p = 0; p < 8; p++) begin
      wr(22'h140000 | 22'(p << 6), 1'b0, 1'b1);
      chk("park_ohm", 22'(ohm_tab[p]), 22'(park_ohm));
    end
    // Gear-down is never enabled here, so the 5-clock setting is legal.
    // Reserved codes give no latency but still count as checking on.
    for (int l = 0; l < 8; l++) begin
      wr(22'h140000 | 22'(l), 1'b0, 1'b1);
      chk("par_lat", 22'(lat_tab[l]), 22'(par_lat));
      chk("par_check", 22'(l != 0), 22'(par_chk));
    end
    wr(22'h140004, 1'b1, 1'b0);
    chk("par_check", 22'h0, 22'(par_chk));
    wr(22'h100000, 1'b1, 1'b1);
    wr(22'h140214, 1'b0, 1'b1);
    wr(22'h140204, 1'b0, 1'b1);
    chk("par_check", 22'h1, 22'(par_chk));
    wr(22'h100000, 1'b1, 1'b0);
    chk("par_check", 22'h1, 22'(par_chk));
    wr(22'h140004, 1'b0, 1'b1);
    crc_err = 1'b1;
    tick(1);
    crc_err = 1'b0;
    tick(1);
    exp[3] = 1'b1;
    chk("crc_flag", exp, mode_reg);
    wr(22'h14000C, 1'b0, 1'b1);
    wr(22'h140004, 1'b0, 1'b1);
    chk("cmd_addr", 22'h000004, 22'(cmd.addr));
    print_verdict();
  end
endmodule
`default_nettype wire
